// *** tcou_pkg.sv ***
// package with constants for the timer compare output unit
package tcou_pkg;
    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_CONTROL   = 4'h0;
    localparam logic [3:0] ADDR_COUNTER   = 4'h1;
    localparam logic [3:0] ADDR_COMPARE   = 4'h2;
    localparam logic [3:0] ADDR_STATUS    = 4'h3;
    localparam logic [3:0] ADDR_MASK      = 4'h4;
    localparam logic [3:0] ADDR_PORT      = 4'h5;
    // ------------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------------
    localparam int CTL_WGM_LSB   = 0;
    localparam int CTL_COM_LSB   = 2;
    localparam int CTL_FORCE_BIT = 4;
    localparam int CTL_RUN_BIT   = 5;
    // port register fields
    localparam int PORT_DATA_BIT = 0;
    localparam int PORT_DIR_BIT  = 1;
    // status / mask fields
    localparam int STAT_MATCH_BIT = 0;
    localparam int STAT_WRAP_BIT  = 1;
    // ------------------------------------------------------------------
    // encodings and reset values
    // ------------------------------------------------------------------
    localparam logic [1:0] WGM_NORMAL   = 2'h0;
    localparam logic [1:0] WGM_PWM_PC   = 2'h1;
    localparam logic [1:0] WGM_CTC      = 2'h2;
    localparam logic [1:0] WGM_PWM_FAST = 2'h3;
    localparam logic [1:0] COM_NONE     = 2'h0;
    localparam logic [1:0] COM_TOGGLE   = 2'h1;
    localparam logic [1:0] COM_CLEAR    = 2'h2;
    localparam logic [1:0] COM_SET      = 2'h3;
    localparam logic [7:0] BYTE_ZERO    = 8'h00;
    localparam logic [7:0] BYTE_MAX     = 8'hff;
    localparam logic [7:0] BYTE_ONE     = 8'h01;
endpackage

// *** tcou_top.sv ***
// timer compare output unit: compare value, force, write blocking, pin override
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ns

module tcou_top (
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    input  wire logic       timer_tick,
    input  wire logic       pin_in,
    output logic            pin_out,
    output logic            pin_oe_n,
    output logic            irq
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [1:0] waveform_select;
    logic [1:0] compare_output_action;
    logic       run_reg;
    logic [7:0] counter_value;
    logic       count_down_reg;
    logic [7:0] compare_value_reg;
    logic [7:0] compare_buffer_reg;
    logic       compare_output_state;
    logic       block_reg;
    logic       match_pend_reg;
    logic [1:0] status_reg;
    logic [1:0] mask_reg;
    logic       port_data_reg;
    logic       compare_pin_direction_bit;
    logic [7:0] rdata_next;

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    wire wr_ctl  = reg_write && (reg_addr == tcou_pkg::ADDR_CONTROL);
    wire wr_cnt  = reg_write && (reg_addr == tcou_pkg::ADDR_COUNTER);
    wire wr_cmp  = reg_write && (reg_addr == tcou_pkg::ADDR_COMPARE);
    wire wr_mask = reg_write && (reg_addr == tcou_pkg::ADDR_MASK);
    wire wr_port = reg_write && (reg_addr == tcou_pkg::ADDR_PORT);
    wire rd_stat = reg_read && (reg_addr == tcou_pkg::ADDR_STATUS);

    wire is_pwm      = (waveform_select == tcou_pkg::WGM_PWM_PC) ||
                       (waveform_select == tcou_pkg::WGM_PWM_FAST);
    wire double_buf  = is_pwm;
    wire tick        = timer_tick && run_reg;
    wire at_top      = (counter_value == tcou_pkg::BYTE_MAX);
    wire at_bottom   = (counter_value == tcou_pkg::BYTE_ZERO);
    wire ctc_top     = (waveform_select == tcou_pkg::WGM_CTC) && (counter_value == compare_value_reg);
    wire raw_match   = (counter_value == compare_value_reg);
    wire match_now   = tick && raw_match && !block_reg;
    wire force_hit   = wr_ctl && reg_wdata[tcou_pkg::CTL_FORCE_BIT] && !is_pwm;
    // new action from the same control write applies to the forced match
    wire [1:0] act_for_force = reg_wdata[tcou_pkg::CTL_COM_LSB +: 2];
    // pwm update point: top for fast pwm, both turning points (top, and one while counting down) for phase correct
    wire pwm_update  = tick && ((waveform_select == tcou_pkg::WGM_PWM_FAST) ? at_top :
                                (at_top || (count_down_reg && counter_value == tcou_pkg::BYTE_ONE)));
    wire wrap_event  = tick && at_bottom;

    // next output state at a match, by action and mode
    function automatic logic oc_apply(input logic cur, input logic [1:0] act, input logic pwm,
                                      input logic down);
        logic r;
        r = cur;
        if (act == tcou_pkg::COM_NONE) begin
            r = cur;
        end else if (!pwm) begin
            unique case (act)
                tcou_pkg::COM_TOGGLE: r = !cur;
                tcou_pkg::COM_CLEAR:  r = 1'b0;
                default:              r = 1'b1;
            endcase
        end else if (act == tcou_pkg::COM_CLEAR) begin
            r = down;
        end else if (act == tcou_pkg::COM_SET) begin
            r = !down;
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            waveform_select       <= tcou_pkg::WGM_NORMAL;
            compare_output_action <= tcou_pkg::COM_NONE;
            run_reg               <= 1'b0;
        end else if (wr_ctl) begin
            waveform_select       <= reg_wdata[tcou_pkg::CTL_WGM_LSB +: 2];
            compare_output_action <= reg_wdata[tcou_pkg::CTL_COM_LSB +: 2];
            run_reg               <= reg_wdata[tcou_pkg::CTL_RUN_BIT];
        end
    end

    // ------------------------------------------------------------------
    // interrupt mask register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mask_reg <= 2'h0;
        end else if (wr_mask) begin
            mask_reg <= reg_wdata[1:0];
        end
    end

    // ------------------------------------------------------------------
    // port register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            port_data_reg             <= 1'b0;
            compare_pin_direction_bit <= 1'b0;
        end else if (wr_port) begin
            port_data_reg             <= reg_wdata[tcou_pkg::PORT_DATA_BIT];
            compare_pin_direction_bit <= reg_wdata[tcou_pkg::PORT_DIR_BIT];
        end
    end

    // ------------------------------------------------------------------
    // counter and write blocking
    // ------------------------------------------------------------------
    // counter steps and the phase correct turn
    wire [7:0] cnt_inc = counter_value + tcou_pkg::BYTE_ONE;
    wire [7:0] cnt_dec = counter_value - tcou_pkg::BYTE_ONE;
    wire       pc_down = at_top || (count_down_reg && !at_bottom);
    wire       pc_last = (counter_value == tcou_pkg::BYTE_ONE);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            counter_value  <= tcou_pkg::BYTE_ZERO;
            count_down_reg <= 1'b0;
            block_reg      <= 1'b0;
        end else begin
            if (wr_cnt) begin
                counter_value <= reg_wdata; // cpu write has priority
                block_reg     <= 1'b1;
            end else if (tick) begin
                block_reg <= 1'b0;
                if (waveform_select == tcou_pkg::WGM_PWM_PC) begin
                    if (pc_down) begin
                        counter_value  <= cnt_dec;
                        count_down_reg <= !pc_last;
                    end else begin
                        counter_value  <= cnt_inc;
                        count_down_reg <= 1'b0;
                    end
                end else if (ctc_top) begin
                    counter_value <= tcou_pkg::BYTE_ZERO;
                end else begin
                    counter_value  <= cnt_inc;
                    count_down_reg <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // compare value and buffer
    // ------------------------------------------------------------------
    // direct write outside pwm, reload from the buffer at the update point
    wire cmp_direct = wr_cmp && !double_buf;
    wire cmp_reload = double_buf && pwm_update;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            compare_value_reg  <= tcou_pkg::BYTE_ZERO;
            compare_buffer_reg <= tcou_pkg::BYTE_ZERO;
        end else begin
            if (wr_cmp) begin
                compare_buffer_reg <= reg_wdata;
            end
            if (cmp_direct) begin
                compare_value_reg <= reg_wdata;
            end else if (cmp_reload) begin
                compare_value_reg <= compare_buffer_reg;
            end
        end
    end

    // ------------------------------------------------------------------
    // output state
    // ------------------------------------------------------------------
    // fast pwm restores at bottom the level that the match took away
    wire fast_bottom = tick && at_bottom && (waveform_select == tcou_pkg::WGM_PWM_FAST);
    wire bottom_high = (compare_output_action == tcou_pkg::COM_CLEAR);
    wire bottom_low  = (compare_output_action == tcou_pkg::COM_SET);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            compare_output_state <= 1'b0;
        end else begin
            // mode changes do not touch the state
            if (force_hit) begin
                compare_output_state <= oc_apply(compare_output_state, act_for_force, 1'b0, 1'b0);
            end else if (match_now) begin
                compare_output_state <= oc_apply(compare_output_state, compare_output_action, is_pwm,
                                                 count_down_reg);
            end else if (fast_bottom && bottom_high) begin
                compare_output_state <= 1'b1;
            end else if (fast_bottom && bottom_low) begin
                compare_output_state <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // match flag delay
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            match_pend_reg <= 1'b0;
        end else if (match_now) begin
            match_pend_reg <= 1'b1;
        end else if (tick) begin
            match_pend_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // interrupt status
    // ------------------------------------------------------------------
    // set wins over read-clear
    wire match_flag_set  = match_pend_reg && tick;
    wire stat_match_next = match_flag_set || (status_reg[tcou_pkg::STAT_MATCH_BIT] && !rd_stat);
    wire stat_wrap_next  = wrap_event || (status_reg[tcou_pkg::STAT_WRAP_BIT] && !rd_stat);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            status_reg <= 2'h0;
        end else begin
            status_reg[tcou_pkg::STAT_MATCH_BIT] <= stat_match_next;
            status_reg[tcou_pkg::STAT_WRAP_BIT]  <= stat_wrap_next;
        end
    end

    // ------------------------------------------------------------------
    // pin override and read data
    // ------------------------------------------------------------------
    wire override = (compare_output_action != tcou_pkg::COM_NONE);
    assign pin_out  = override ? compare_output_state : port_data_reg;
    assign pin_oe_n = !compare_pin_direction_bit;
    assign irq      = |(status_reg & mask_reg);

    always_comb begin
        rdata_next = tcou_pkg::BYTE_ZERO;
        unique case (reg_addr)
            tcou_pkg::ADDR_CONTROL: rdata_next = {2'h0, run_reg, 1'b0, compare_output_action, waveform_select};
            tcou_pkg::ADDR_COUNTER: rdata_next = counter_value;
            tcou_pkg::ADDR_COMPARE: rdata_next = double_buf ? compare_buffer_reg : compare_value_reg;
            tcou_pkg::ADDR_STATUS:  rdata_next = {6'h00, status_reg};
            tcou_pkg::ADDR_MASK:    rdata_next = {6'h00, mask_reg};
            tcou_pkg::ADDR_PORT:    rdata_next = {4'h0, pin_in, compare_output_state,
                                                  compare_pin_direction_bit, port_data_reg};
            default:                rdata_next = tcou_pkg::BYTE_ZERO;
        endcase
    end

    // ------------------------------------------------------------------
    // read data register, zero outside the read answer cycle
    // ------------------------------------------------------------------

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= tcou_pkg::BYTE_ZERO;
        end else begin
            reg_rdata <= reg_read ? rdata_next : tcou_pkg::BYTE_ZERO;
        end
    end
endmodule

// *** tcou_monitor.sv ***
// port checker for the timer compare output unit
`timescale 1ns/1ns
module tcou_monitor (
    input wire logic       sys_clk,
    input wire logic       reset_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic       timer_tick,
    input wire logic       pin_in,
    input wire logic       pin_out,
    input wire logic       pin_oe_n,
    input wire logic       irq
);
    // ------------------------------------------------------------------
    // shadow of control, port and counter writes
    // ------------------------------------------------------------------
    logic [7:0] ctl_q;
    logic [7:0] port_q;
    logic       blk_q;
    wire        wr_ctl  = reg_write && reg_addr == tcou_pkg::ADDR_CONTROL;
    wire        wr_port = reg_write && reg_addr == tcou_pkg::ADDR_PORT;
    wire        wr_cnt  = reg_write && reg_addr == tcou_pkg::ADDR_COUNTER;
    wire        run_tk  = timer_tick && ctl_q[tcou_pkg::CTL_RUN_BIT];
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctl_q  <= 8'h00;
            port_q <= 8'h00;
            blk_q  <= 1'b0;
        end else begin
            ctl_q  <= wr_ctl ? reg_wdata : ctl_q;
            port_q <= wr_port ? reg_wdata : port_q;
            blk_q  <= wr_cnt ? 1'b1 : (run_tk ? 1'b0 : blk_q);
        end
    end
    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    reset_state_a: assert property ($rose(reset_n) |-> pin_out == 1'b0 && pin_oe_n && !irq)
        else $error("outputs not cleared after reset");
    dir_enable_a: assert property (wr_port |=> pin_oe_n == !$past(reg_wdata[tcou_pkg::PORT_DIR_BIT]))
        else $error("output enable does not follow direction bit");
    force_reads_zero_a: assert property (reg_read && reg_addr == tcou_pkg::ADDR_CONTROL |=> !reg_rdata[4])
        else $error("force bit read back as one");
    port_source_a: assert property (ctl_q[3:2] == 2'h0 |-> pin_out == port_q[0])
        else $error("pin not from port data with action zero");
    mode_keeps_state_a: assert property (wr_ctl && reg_wdata[3:2] == ctl_q[3:2] && !reg_wdata[4] && !timer_tick
        |=> $stable(pin_out))
        else $error("pin changed on mode-only write");
    force_set_clear_a: assert property (wr_ctl && reg_wdata[4] && !reg_wdata[0] && reg_wdata[3] && !timer_tick
        |=> pin_out == $past(reg_wdata[2]))
        else $error("forced set or clear not on pin");
    write_block_a: assert property (blk_q && run_tk && !reg_write |=> $stable(pin_out))
        else $error("match not blocked after counter write");
    irq_cause_a: assert property ($rose(irq) |-> $past(timer_tick) || $past(reg_write))
        else $error("interrupt rose without tick or write");
    status_clear_a: assert property (reg_read && reg_addr == tcou_pkg::ADDR_STATUS && !timer_tick |=> !irq)
        else $error("interrupt held after status read");
endmodule

bind tcou_top tcou_monitor u_mon (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .timer_tick(timer_tick), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .irq(irq));

// *** tcou_pin_model.sv ***
// far side: port pin with pull-up, resolved from the unit's drive
`timescale 1ns/1ns
module tcou_pin_model (
    input  wire logic pin_out,
    input  wire logic pin_oe_n,
    output logic      pin_level
);
    // released pin floats to the pull-up level
    assign pin_level = pin_oe_n ? 1'b1 : pin_out;
endmodule

// *** testbench.sv ***
// self-checking testbench for the timer compare output unit
`timescale 1ns/1ns
module testbench;
    logic       sys_clk    = 1'b0;
    logic       reset_n    = 1'b0;
    logic [3:0] reg_addr   = 4'h0;
    logic [7:0] reg_wdata  = 8'h00;
    logic       reg_write  = 1'b0;
    logic       reg_read   = 1'b0;
    logic       timer_tick = 1'b0;
    logic [7:0] reg_rdata;
    logic       pin_in;
    logic       pin_out;
    logic       pin_oe_n;
    logic       irq;
    int         num_errors      = 0;
    int         samples_checked = 0;
    always #4 sys_clk = ~sys_clk;
    tcou_top u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .timer_tick(timer_tick),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .irq(irq));
    tcou_pin_model u_pin (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_level(pin_in));
    // ------------------------------------------------------------------
    // bus and compare helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_write <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1;
        check(reg_rdata & m, exp);
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            timer_tick <= 1'b1;
            @(posedge sys_clk);
            timer_tick <= 1'b0;
        end
        #1;
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        check({6'h0, pin_oe_n, pin_out}, 8'h02);
        rd(tcou_pkg::ADDR_PORT, 8'h04, 8'h00);
        rd(4'hf, 8'hff, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_force();
        logic [1:0] act [4] = '{tcou_pkg::COM_SET, tcou_pkg::COM_CLEAR, tcou_pkg::COM_TOGGLE, tcou_pkg::COM_NONE};
        logic [7:0] st [4]  = '{8'h04, 8'h00, 8'h04, 8'h04};
        for (int i = 0; i < 4; i++) begin
            wr(tcou_pkg::ADDR_CONTROL, {3'h0, 1'b1, act[i], tcou_pkg::WGM_NORMAL});
            rd(tcou_pkg::ADDR_PORT, 8'h04, st[i]);
            rd(tcou_pkg::ADDR_CONTROL, 8'h1f, {4'h0, act[i], 2'h0});
        end
        rd(tcou_pkg::ADDR_STATUS, 8'hff, 8'h00);
        rd(tcou_pkg::ADDR_COUNTER, 8'hff, 8'h00);
        check({7'h0, pin_oe_n}, 8'h01);
        $display("test force done");
    endtask
    task automatic t_pin();
        wr(tcou_pkg::ADDR_PORT, 8'h02);
        check({6'h0, pin_oe_n, pin_out}, 8'h00);
        rd(tcou_pkg::ADDR_PORT, 8'h08, 8'h00);
        wr(tcou_pkg::ADDR_CONTROL, 8'h0c);
        check({6'h0, pin_oe_n, pin_out}, 8'h01);
        wr(tcou_pkg::ADDR_CONTROL, 8'h0f);
        check({6'h0, pin_oe_n, pin_out}, 8'h01);
        rd(tcou_pkg::ADDR_PORT, 8'h04, 8'h04);
        wr(tcou_pkg::ADDR_CONTROL, 8'h1b);
        rd(tcou_pkg::ADDR_PORT, 8'h04, 8'h04);
        wr(tcou_pkg::ADDR_COMPARE, 8'h33);
        rd(tcou_pkg::ADDR_COMPARE, 8'hff, 8'h33);
        $display("test pin done");
    endtask
    task automatic t_match();
        wr(tcou_pkg::ADDR_MASK, 8'h01);
        wr(tcou_pkg::ADDR_CONTROL, 8'h04);
        wr(tcou_pkg::ADDR_COMPARE, 8'h05);
        wr(tcou_pkg::ADDR_COUNTER, 8'h05);
        wr(tcou_pkg::ADDR_CONTROL, 8'h24);
        tick(1);
        rd(tcou_pkg::ADDR_PORT, 8'h04, 8'h04);
        tick(255);
        rd(tcou_pkg::ADDR_COUNTER, 8'hff, 8'h05);
        rd(tcou_pkg::ADDR_STATUS, 8'h01, 8'h00);
        tick(1);
        rd(tcou_pkg::ADDR_PORT, 8'h04, 8'h00);
        check({7'h0, irq}, 8'h00);
        tick(1);
        check({7'h0, irq}, 8'h01);
        rd(tcou_pkg::ADDR_STATUS, 8'h01, 8'h01);
        check({7'h0, irq}, 8'h00);
        $display("test match done");
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_reset();
        t_force();
        t_pin();
        t_match();
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        end_of_test();
    end
endmodule
